// >>> oaap_chk.sv
// assertions on the converter access port
`default_nettype none
`include "oaap_defs.svh"
module oaap_chk
(
    // clock, reset and bus
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // converter side and strap
    input wire logic conv_start,
    input wire logic [2:0] conv_channel,
    input wire logic conv_bipolar,
    input wire logic conv_range_10v,
    input wire logic option_fitted
);
    timeunit 1ns;
    timeprecision 1ps;
    // decoded bus events
    wire logic acc = psel && penable && pready;
    wire logic cw = acc && pwrite && paddr == `OAAP_OFF_CTRL && pstrb[0];
    wire logic rdd = acc && !pwrite;
    wire logic mapped = paddr inside {`OAAP_OFF_STATUS, `OAAP_OFF_CTRL, `OAAP_OFF_RES_HI,
        `OAAP_OFF_PRESENT, `OAAP_OFF_IRQ_STAT, `OAAP_OFF_IRQ_MASK};
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence ctrl_wr;
        cw;
    endsequence
    sequence busy_read;
        conv_start ##[1:9] (rdd && paddr == `OAAP_OFF_STATUS);
    endsequence
    chk_start_pulse: assert property (ctrl_wr |=> conv_start)
        else $error("no start after control write");
    chk_channel_field: assert property (ctrl_wr |=> conv_channel == $past(pwdata[2:0]))
        else $error("channel field wrong");
    chk_polarity_field: assert property (ctrl_wr |=> conv_bipolar == $past(pwdata[3]))
        else $error("polarity field wrong");
    chk_range_field: assert property (ctrl_wr |=> conv_range_10v == $past(pwdata[4]))
        else $error("range field wrong");
    chk_busy_status: assert property (busy_read |-> prdata[7])
        else $error("status not busy during conversion");
    chk_unmapped_err: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 0))
        else $error("unmapped access not refused");
    chk_present_bit: assert property (rdd && paddr == `OAAP_OFF_PRESENT |-> prdata[0] == option_fitted)
        else $error("presence bit wrong");
    chk_sign_ext: assert property (rdd && paddr == `OAAP_OFF_CTRL |-> prdata[31:16] == 0
        && prdata[15:12] == (conv_bipolar ? {4{prdata[11]}} : 4'h0))
        else $error("result upper bits wrong");
    chk_high_byte: assert property (rdd && paddr == `OAAP_OFF_RES_HI |-> prdata[31:8] == 0)
        else $error("high byte read not byte wide");
endmodule
bind oaap_top oaap_chk oaap_chk_i(.*);
`default_nettype wire

// >>> oaap_conv_model.sv
// behavioural stand-in for the external converter chip
`default_nettype none
module oaap_conv_model #(parameter int DLY = 5)
(
    // start and analog level
    input wire logic clk,
    input wire logic conv_start,
    input wire logic [11:0] level,
    // sample out
    output logic [11:0] conv_sample
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] held = 12'h000;
    int n = 0;
    // hold level at start, shifting garbage until settled
    always @(posedge clk)
    begin
        n <= conv_start ? 0 : n + 1;
        if (conv_start)
            held <= level;
        conv_sample <= (n >= DLY) ? held : held ^ 12'(n + 1);
    end
endmodule
`default_nettype wire

// >>> oaap_conv_timer.sv
// countdown timer that marks the end of a conversion
`default_nettype none
module oaap_conv_timer
    import oaap_pkg::*;
#(
    parameter int CYCLES = 300
)
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // control
    input wire logic start,
    output logic done
);
    typedef struct packed
    {
        logic [15:0] cnt;
        logic run;
        logic done;
    } oaap_tmr_s;

    oaap_tmr_s st_q;
    oaap_tmr_s st_d;

    // count down from the full figure, pulse done on reaching one
    always_comb
    begin
        st_d = st_q;
        st_d.done = 1'b0;
        if (start)
        begin
            st_d.cnt = 16'(CYCLES);
            st_d.run = 1'b1;
        end
        else if (st_q.run)
        begin
            if (st_q.cnt <= 16'h0001)
            begin
                st_d.run = 1'b0;
                st_d.done = 1'b1;
            end
            else
            begin
                st_d.cnt = st_q.cnt - 16'h0001;
            end
        end
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign done = st_q.done;
endmodule
`default_nettype wire

// >>> oaap_defs.svh
// register offsets, field positions and timing constants for the converter access port
`ifndef OAAP_DEFS_SVH
`define OAAP_DEFS_SVH
`define OAAP_ADDR_W 32
`define OAAP_OFF_STATUS 32'h1080_0000
`define OAAP_OFF_CTRL 32'h10F0_0000
`define OAAP_OFF_RES_HI 32'h10F0_0001
`define OAAP_OFF_PRESENT 32'h2240_0000
`define OAAP_OFF_IRQ_STAT 32'h1080_0004
`define OAAP_OFF_IRQ_MASK 32'h1080_0008
`define OAAP_CH_LSB 0
`define OAAP_CH_MSB 2
`define OAAP_BIPOLAR_BIT 3
`define OAAP_RANGE_BIT 4
`define OAAP_BUSY_BIT 7
`define OAAP_SIGN_BIT 11
`define OAAP_CONV_TIME_NS 12000
`define OAAP_CLK_PERIOD_NS 40
`define OAAP_IRQ_DONE_BIT 0
`define OAAP_IRQ_WIDTH 1
`define OAAP_RES_WIDTH 12
`define OAAP_NUM_CH 8
`endif

// >>> oaap_pkg.sv
// types shared by the converter access port modules
`default_nettype none
package oaap_pkg;
    typedef enum logic [1:0] {
        OAAP_IDLE = 2'b00,
        OAAP_CONV = 2'b01,
        OAAP_LATCH = 2'b11
    } oaap_state_e;
endpackage
`default_nettype wire

// >>> oaap_result_fmt.sv
// registered formatter turning a raw 12-bit sample into the 16-bit result word
`default_nettype none
`include "oaap_defs.svh"
module oaap_result_fmt
    import oaap_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // raw sample in
    input wire logic load,
    input wire logic bipolar,
    input wire logic [11:0] raw,
    // formatted word out
    output logic [15:0] word
);
    typedef struct packed
    {
        logic [15:0] word;
    } oaap_fmt_s;

    oaap_fmt_s st_q;
    oaap_fmt_s st_d;

    // zero fill for unipolar, sign fill for bipolar
    always_comb
    begin
        st_d = st_q;
        if (load)
        begin
            if (bipolar)
                st_d.word = {{4{raw[`OAAP_SIGN_BIT]}}, raw};
            else
                st_d.word = {4'h0, raw};
        end
    end

    // result register
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign word = st_q.word;
endmodule
`default_nettype wire

// >>> oaap_tb.sv
// self-checking bench for the converter access port
`default_nettype none
`include "oaap_defs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, fit = 1;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd, r = 32'h0000_59b4;
    logic [3:0] pstrb = 0;
    logic [11:0] level = 0, smp;
    logic [2:0] ch;
    logic pready, pslverr, irq, er, cs, bp, rg;
    int bad_count = 0, samples_checked = 0, cyc = 0;
    int q[$];
    oaap_top #(.CONV_TIME_NS(400)) oaap_top_i(.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_start(cs), .conv_channel(ch),
        .conv_bipolar(bp), .conv_range_10v(rg), .conv_sample(smp), .option_fitted(fit), .irq(irq));
    oaap_conv_model oaap_conv_model_i(.clk(clk), .conv_start(cs), .level(level), .conv_sample(smp));
    // free running clock
    initial
    begin
        forever #20 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        r ^= r << 13;
        r ^= r >> 17;
        r ^= r << 5;
        return r;
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, got);
        samples_checked++;
        if (got !== ex)
        begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", nm, ex, got);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1;
        // wait for the answer; only the cycle ceiling ends a hang
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic conv(input logic [4:0] c);
        int k = 0;
        logic [31:0] rn;
        rn = xs();
        level <= rn[11:0];
        q.push_back({c[3] ? {4{rn[11]}} : 4'h0, rn[11:0]});
        apb(1, `OAAP_OFF_CTRL, {24'h0, 3'b010, c}, 4'h1);
        apb(0, `OAAP_OFF_STATUS, 0, 0);
        chk("busy", 1, rd[7]);
        chk("fields", {27'h0, c}, {rg, bp, ch});
        // poll until done before fetching the result
        while (rd[7] !== 1'b0 && k < 40)
        begin
            apb(0, `OAAP_OFF_STATUS, 0, 0);
            k++;
        end
        chk("done", 0, rd[7]);
        apb(0, `OAAP_OFF_CTRL, 0, 0);
        chk("word", q[0], rd);
        apb(0, `OAAP_OFF_RES_HI, 0, 0);
        chk("high", q.pop_front() >> 8, rd);
    endtask
    // cycle ceiling against hangs
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            bad_count++;
            stop_test();
        end
    end
    // main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        sys_rst <= 0;
        apb(0, `OAAP_OFF_PRESENT, 0, 0);
        chk("fitted", 1, rd);
        apb(1, `OAAP_OFF_IRQ_MASK, 1, 4'hF);
        for (int i = 0; i < 8; i++)
        begin
            conv({i[1:0], i[2:0]});
            chk("irq", 1, irq);
            apb(1, `OAAP_OFF_IRQ_STAT, 1, 4'hF);
            repeat (2) @(posedge clk);
            chk("irq_clr", 0, irq);
        end
        apb(1, `OAAP_OFF_IRQ_MASK, 0, 4'hF);
        conv(5'h1b);
        chk("irq_mask", 0, irq);
        apb(0, `OAAP_OFF_IRQ_STAT, 0, 0);
        chk("irq_stat", 1, rd);
        apb(0, `OAAP_OFF_IRQ_MASK, 0, 0);
        chk("mask_rd", 0, rd);
        apb(0, 32'h1080_000c, 0, 0);
        chk("unmapped", 3, {rd == 0, er});
        apb(1, `OAAP_OFF_CTRL, 32'h0000_0040, 4'h2);
        apb(0, `OAAP_OFF_STATUS, 0, 0);
        chk("no_start", 0, rd[7]);
        fit <= 0;
        repeat (2) @(posedge clk);
        apb(0, `OAAP_OFF_PRESENT, 0, 0);
        chk("absent", 0, rd);
        stop_test();
    end
endmodule
`default_nettype wire

// >>> oaap_top.sv
// APB access port for the optional eight-channel 12-bit converter
//
// Our own choice: the APB interface to the registers.
`default_nettype none
`include "oaap_defs.svh"
module oaap_top
    import oaap_pkg::*;
#(
    parameter int CONV_TIME_NS = `OAAP_CONV_TIME_NS,
    parameter int NUM_CH = `OAAP_NUM_CH
)
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter chip side
    output logic conv_start,
    output logic [2:0] conv_channel,
    output logic conv_bipolar,
    output logic conv_range_10v,
    input wire logic [11:0] conv_sample,
    // board strap
    input wire logic option_fitted,
    // interrupt
    output logic irq
);
    // least time rounded up to whole cycles
    localparam int CONV_CYCLES = (CONV_TIME_NS + `OAAP_CLK_PERIOD_NS - 1) / `OAAP_CLK_PERIOD_NS;

    typedef struct packed
    {
        oaap_state_e state;
        logic [2:0] channel;
        logic bipolar;
        logic range_10v;
        logic start;
        logic busy;
        logic fitted;
        logic irq_stat;
        logic irq_mask;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } oaap_top_s;

    oaap_top_s st_q;
    oaap_top_s st_d;
    logic timer_done;
    logic [15:0] result_word;
    logic result_load;

    // conversion time counter
    oaap_conv_timer #(
        .CYCLES(CONV_CYCLES)
    ) u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(st_q.start),
        .done(timer_done)
    );

    // result formatting register
    oaap_result_fmt u_fmt (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(result_load),
        .bipolar(st_q.bipolar),
        .raw(conv_sample),
        .word(result_word)
    );

    assign result_load = (st_q.state == OAAP_CONV) && timer_done;

    // bus decode, conversion sequence and interrupt
    always_comb
    begin
        logic setup;
        logic wr;
        logic done_evt;
        setup = psel && !penable;
        wr = psel && penable && pwrite && st_q.pready;
        done_evt = (st_q.state == OAAP_LATCH);
        st_d = st_q;
        st_d.start = 1'b0;
        st_d.pready = 1'b0;
        st_d.pslverr = 1'b0;
        st_d.fitted = option_fitted;
        // conversion sequence
        unique case (st_q.state)
            OAAP_IDLE:
            begin
            end
            OAAP_CONV:
            begin
                if (timer_done)
                    st_d.state = OAAP_LATCH;
            end
            OAAP_LATCH:
            begin
                st_d.state = OAAP_IDLE;
                st_d.busy = 1'b0;
            end
            default:
            begin
                st_d.state = OAAP_IDLE;
            end
        endcase
        // sticky done flag, set wins over clear
        if (wr && paddr == `OAAP_OFF_IRQ_STAT && pwdata[`OAAP_IRQ_DONE_BIT])
            st_d.irq_stat = 1'b0;
        if (done_evt)
            st_d.irq_stat = 1'b1;
        // no wait state: answer in the cycle after setup
        if (setup)
        begin
            st_d.pready = 1'b1;
            st_d.prdata = 32'h0000_0000;
            if (pwrite)
            begin
                // bus writes take effect in the access phase, the irq_stat clear above and the other writes below
                if (paddr != `OAAP_OFF_CTRL && paddr != `OAAP_OFF_IRQ_STAT && paddr != `OAAP_OFF_IRQ_MASK)
                    st_d.pslverr = 1'b1;
            end
            else
            begin
                unique case (paddr)
                    `OAAP_OFF_STATUS:
                        st_d.prdata[`OAAP_BUSY_BIT] = st_q.busy;
                    `OAAP_OFF_CTRL:
                        st_d.prdata[15:0] = result_word;
                    `OAAP_OFF_RES_HI:
                        st_d.prdata[7:0] = result_word[15:8];
                    `OAAP_OFF_PRESENT:
                        st_d.prdata[0] = st_q.fitted;
                    `OAAP_OFF_IRQ_STAT:
                        st_d.prdata[`OAAP_IRQ_DONE_BIT] = st_q.irq_stat;
                    `OAAP_OFF_IRQ_MASK:
                        st_d.prdata[`OAAP_IRQ_DONE_BIT] = st_q.irq_mask;
                    default:
                        st_d.pslverr = 1'b1;
                endcase
            end
        end
        // register writes
        if (wr)
        begin
            if (paddr == `OAAP_OFF_CTRL && pstrb[0])
            begin
                st_d.channel = pwdata[`OAAP_CH_MSB:`OAAP_CH_LSB];
                st_d.bipolar = pwdata[`OAAP_BIPOLAR_BIT];
                st_d.range_10v = pwdata[`OAAP_RANGE_BIT];
                st_d.start = 1'b1;
                st_d.busy = 1'b1;
                st_d.state = OAAP_CONV;
            end
            if (paddr == `OAAP_OFF_IRQ_MASK)
                st_d.irq_mask = pwdata[`OAAP_IRQ_DONE_BIT];
        end
        st_d.irq = st_d.irq_stat && st_d.irq_mask;
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    // outputs straight from flip-flops
    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign conv_start = st_q.start;
    assign conv_channel = st_q.channel;
    assign conv_bipolar = st_q.bipolar;
    assign conv_range_10v = st_q.range_10v;
    assign irq = st_q.irq;
endmodule
`default_nettype wire
